// *** scp_port.sv ***
`default_nettype none
`include "scp_params.svh"

// Behaviour
// - Rate returns to 9600 after reset.
// - 8N1 ASCII framing, XON/XOFF flow control.
// - Command letters decoded case-insensitively.
// - Responses end with single CR.
// - Printing active blocks host communication.
// - Link ignored until initialisation done.
// - Port serves printer, download, online, offline.
// - No remote control of instrument functions.
// - Rate commands select 9600, 19200, 38400.
module scp_port #(
  parameter int CLK_HZ = `SCP_CLK_HZ  // Core clock rate in hertz
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  // Instrument status
  input  wire logic               init_done_in,
  input  wire logic               print_active_in,
  // Serial line
  input  wire logic               rxd_in,
  output logic                    txd_out,
  // Response bytes from firmware
  input  wire logic               resp_valid_in,
  input  wire scp_pkg::scp_byte_t resp_data_in,
  input  wire logic               resp_last_in,
  output logic                    resp_ready_out,
  // Decoded command towards firmware
  output logic                    cmd_valid_out,
  output scp_pkg::scp_byte_t      cmd_first_out,
  output scp_pkg::scp_byte_t      cmd_second_out,
  output logic [`SCP_CMD_CNT_W-1:0] cmd_len_out,
  // Status
  output scp_pkg::scp_rate_t      rate_out,
  output logic                    host_paused_out
);
  import scp_pkg::*;

  typedef enum logic [1:0] {
    SCP_TX_IDLE, SCP_TX_START, SCP_TX_DATA, SCP_TX_STOP
  } scp_tx_state_t;

  typedef struct packed {
    scp_rate_t                 rate;    // Current line rate
    scp_byte_t                 c0;      // First command char
    scp_byte_t                 c1;      // Second command char
    logic [`SCP_CMD_CNT_W-1:0] len;     // Chars seen, saturating
    logic                      after_cr;// Last char was CR
    logic                      cmd_v;   // Command strobe
    scp_byte_t                 o0;      // Latched command chars
    scp_byte_t                 o1;
    logic [`SCP_CMD_CNT_W-1:0] olen;
    logic                      paused;  // XOFF from host
    logic                      pend_cr; // CR owed after response
    scp_tx_state_t             tx;      // Transmitter phase
    logic [`SCP_DIV_W-1:0]     tcnt;    // Clocks left in bit
    logic [`SCP_BIT_CNT_W-1:0] tbits;   // Data bits sent
    scp_byte_t                 tsh;     // Transmit shift
    logic                      txd;     // Line level
  } scp_st_t;

  scp_st_t r;       // Registered state
  scp_st_t next_r;  // Next state

  logic [`SCP_DIV_W-1:0] div;   // Clocks per bit
  logic                  rx_v;  // Byte received
  scp_byte_t             rx_d;  // Received byte
  scp_byte_t             up;    // Upper-cased byte
  logic                  link_on; // Link usable
  logic                  take;  // Response byte accepted

  always_comb begin
    case (r.rate)
      SCP_RATE_SEL_MID:  div = `SCP_DIV_W'(CLK_HZ / `SCP_RATE_MID);
      SCP_RATE_SEL_HIGH: div = `SCP_DIV_W'(CLK_HZ / `SCP_RATE_HIGH);
      default:           div = `SCP_DIV_W'(CLK_HZ / `SCP_RATE_LOW);
    endcase
  end

  scp_uart_rx u_rx (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .div_in    (div),
    .rxd_in    (rxd_in),
    .valid_out (rx_v),
    .data_out  (rx_d)
  );

  assign link_on = init_done_in && !print_active_in;

  assign up = (rx_d >= `SCP_CHAR_LOW_A && rx_d <= `SCP_CHAR_LOW_Z) ?
              (rx_d & ~`SCP_CASE_BIT) : rx_d;

  // one response path for all uses
  // Response byte taken when link usable, transmitter idle, not paused and no CR owed
  assign take = link_on && r.tx == SCP_TX_IDLE && !r.paused &&
                !r.pend_cr && resp_valid_in;
  assign resp_ready_out = link_on && r.tx == SCP_TX_IDLE &&
                          !r.paused && !r.pend_cr;

  // Command assembly and transmitter
  always_comb begin
    next_r       = r;
    next_r.cmd_v = 1'b0;
    if (r.tcnt != '0) begin
      next_r.tcnt = r.tcnt - 1'b1;
    end
    if (!link_on) begin
      // Drop partial command while link unusable
      next_r.len      = '0;
      next_r.after_cr = 1'b0;
      next_r.paused   = 1'b0;
    end else if (rx_v) begin
      if (up == `SCP_CHAR_XOFF) begin
        next_r.paused = 1'b1;
      end else if (up == `SCP_CHAR_XON) begin
        next_r.paused = 1'b0;
      end else if (up == `SCP_CHAR_LF && r.after_cr) begin
        next_r.after_cr = 1'b0;
      end else if (up == `SCP_CHAR_CR) begin
        next_r.after_cr = 1'b1;
        next_r.len      = '0;
        next_r.cmd_v    = 1'b1;
        next_r.o0       = r.c0;
        next_r.o1       = r.c1;
        next_r.olen     = r.len;
        if (r.len == `SCP_CMD_CNT_W'(`SCP_CMD_LEN) &&
            r.c0 == `SCP_CHAR_B) begin
          if (r.c1 == `SCP_CHAR_A) begin
            next_r.rate = SCP_RATE_SEL_LOW;
          end else if (r.c1 == `SCP_CHAR_B) begin
            next_r.rate = SCP_RATE_SEL_MID;
          end else if (r.c1 == `SCP_CHAR_C) begin
            next_r.rate = SCP_RATE_SEL_HIGH;
          end
        end
      end else begin
        next_r.after_cr = 1'b0;
        if (r.len == '0) begin
          next_r.c0 = up;
        end else if (r.len == `SCP_CMD_CNT_W'(1)) begin
          next_r.c1 = up;
        end
        if (r.len != '1) begin
          next_r.len = r.len + 1'b1;
        end
      end
    end
    // Transmitter
    case (r.tx)
      SCP_TX_IDLE: begin
        next_r.txd = 1'b1;
        if (take) begin
          next_r.tsh     = resp_data_in;
          next_r.pend_cr = resp_last_in;
          next_r.tx      = SCP_TX_START;
          // One less so each bit lasts div clocks
          next_r.tcnt    = div - 1'b1;
          next_r.txd     = 1'b0;
        end else if (r.pend_cr && link_on && !r.paused) begin
          next_r.tsh     = `SCP_CHAR_CR;
          next_r.pend_cr = 1'b0;
          next_r.tx      = SCP_TX_START;
          next_r.tcnt    = div - 1'b1;
          next_r.txd     = 1'b0;
        end
      end
      SCP_TX_START: begin
        if (r.tcnt == '0) begin
          next_r.tx    = SCP_TX_DATA;
          next_r.tbits = '0;
          next_r.tcnt  = div - 1'b1;
          next_r.txd   = r.tsh[0];
        end
      end
      SCP_TX_DATA: begin
        if (r.tcnt == '0) begin
          next_r.tcnt  = div - 1'b1;
          next_r.tbits = r.tbits + 1'b1;
          if (r.tbits == `SCP_BIT_CNT_W'(`SCP_DATA_BITS - 1)) begin
            next_r.tx  = SCP_TX_STOP;
            next_r.txd = 1'b1;
          end else begin
            next_r.tsh = r.tsh >> 1;
            next_r.txd = r.tsh[1];
          end
        end
      end
      default: begin
        if (r.tcnt == '0) begin
          next_r.tx = SCP_TX_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      r <= '{rate: SCP_RATE_SEL_LOW, tx: SCP_TX_IDLE, txd: 1'b1,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs
  assign txd_out         = r.txd;
  assign cmd_valid_out   = r.cmd_v;
  assign cmd_first_out   = r.o0;
  assign cmd_second_out  = r.o1;
  assign cmd_len_out     = r.olen;
  assign rate_out        = r.rate;
  assign host_paused_out = r.paused;
endmodule : scp_port

`default_nettype wire

// *** scp_params.svh ***
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// Clock and line rates
`define SCP_CLK_HZ        100000000
`define SCP_RATE_LOW      9600
`define SCP_RATE_MID      19200
`define SCP_RATE_HIGH     38400
// Clocks per bit, derived from the rates
`define SCP_DIV_LOW       (`SCP_CLK_HZ / `SCP_RATE_LOW)
`define SCP_DIV_MID       (`SCP_CLK_HZ / `SCP_RATE_MID)
`define SCP_DIV_HIGH      (`SCP_CLK_HZ / `SCP_RATE_HIGH)
`define SCP_DIV_W         14
// Character framing
`define SCP_DATA_BITS     8
`define SCP_BIT_CNT_W     4
// Characters of the protocol
`define SCP_CHAR_CR       8'h0D
`define SCP_CHAR_LF       8'h0A
`define SCP_CHAR_XON      8'h11
`define SCP_CHAR_XOFF     8'h13
`define SCP_CHAR_A        8'h41
`define SCP_CHAR_B        8'h42
`define SCP_CHAR_C        8'h43
`define SCP_CHAR_LOW_A    8'h61
`define SCP_CHAR_LOW_Z    8'h7A
`define SCP_CASE_BIT      8'h20
// Command buffer depth
`define SCP_CMD_LEN       2
`define SCP_CMD_CNT_W     3

`endif

// *** scp_pkg.sv ***
`default_nettype none
`include "scp_params.svh"

package scp_pkg;
  // Line rate selection
  typedef enum logic [1:0] {
    SCP_RATE_SEL_LOW,
    SCP_RATE_SEL_MID,
    SCP_RATE_SEL_HIGH
  } scp_rate_t;

  // One byte on the line
  typedef logic [`SCP_DATA_BITS-1:0] scp_byte_t;
endpackage : scp_pkg

`default_nettype wire

// *** scp_uart_rx.sv ***
`default_nettype none
`include "scp_params.svh"

// 8N1 receiver, samples mid-bit
module scp_uart_rx (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  // Bit period in clocks
  input  wire logic [`SCP_DIV_W-1:0] div_in,
  // Serial line
  input  wire logic                  rxd_in,
  // Received byte
  output logic                       valid_out,
  output scp_pkg::scp_byte_t         data_out
);
  import scp_pkg::*;

  typedef enum logic [1:0] {
    SCP_RX_IDLE, SCP_RX_START, SCP_RX_DATA, SCP_RX_STOP
  } scp_rx_state_t;

  typedef struct packed {
    scp_rx_state_t             state;   // Frame phase
    logic [`SCP_DIV_W-1:0]     cnt;     // Clocks left in bit
    logic [`SCP_BIT_CNT_W-1:0] bits;    // Data bits taken
    scp_byte_t                 shift;   // Shift register
    logic                      valid;   // Byte strobe
    scp_byte_t                 data;    // Output byte
  } scp_rx_t;

  scp_rx_t r;       // Registered state
  scp_rx_t next_r;  // Next state

  // Frame decoding
  always_comb begin
    next_r       = r;
    next_r.valid = 1'b0;
    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end
    case (r.state)
      SCP_RX_IDLE: begin
        // Falling edge starts a frame
        if (!rxd_in) begin
          next_r.state = SCP_RX_START;
          next_r.cnt   = div_in >> 1;
        end
      end
      SCP_RX_START: begin
        if (r.cnt == '0) begin
          // Mid start bit: glitch check
          if (rxd_in) begin
            next_r.state = SCP_RX_IDLE;
          end else begin
            next_r.state = SCP_RX_DATA;
            // One less so each bit lasts div clocks
            next_r.cnt   = div_in - 1'b1;
            next_r.bits  = '0;
          end
        end
      end
      SCP_RX_DATA: begin
        if (r.cnt == '0) begin
          // LSB first
          next_r.shift = {rxd_in, r.shift[`SCP_DATA_BITS-1:1]};
          next_r.bits  = r.bits + 1'b1;
          next_r.cnt   = div_in - 1'b1;
          if (r.bits == `SCP_BIT_CNT_W'(`SCP_DATA_BITS - 1)) begin
            next_r.state = SCP_RX_STOP;
          end
        end
      end
      default: begin
        if (r.cnt == '0) begin
          // Valid stop bit delivers the byte
          next_r.state = SCP_RX_IDLE;
          if (rxd_in) begin
            next_r.valid = 1'b1;
            next_r.data  = r.shift;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      r <= '{state: SCP_RX_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign valid_out = r.valid;
  assign data_out  = r.data;
endmodule : scp_uart_rx

`default_nettype wire

// *** scp_host.sv ***
`default_nettype none
`include "scp_params.svh"

// Host computer on the far end of the serial link
module scp_host (
  // Clock
  input  wire logic clk_in,
  // Serial lines
  output logic      rxd_out,
  input  wire logic txd_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int         div = `SCP_DIV_LOW; // Clocks per bit
  logic [7:0] got_q[$];           // Bytes heard from the port
  logic [7:0] sh;                 // Receive shift
  initial rxd_out = 1'b1;

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_in);
      rxd_out = f[i];
      repeat (div - 1) @(negedge clk_in);
    end
  endtask : send

  task automatic command(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send(s[i]);
    end
    send(8'h0D);
  endtask : command

  always begin
    @(negedge txd_in);
    repeat (div / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk_in);
      sh[i] = txd_in;
    end
    repeat (div) @(posedge clk_in);
    got_q.push_back(sh);
  end
endmodule : scp_host

`default_nettype wire

// *** scp_port_sva.sv ***
`default_nettype none

// Boundary checks of the command port
module scp_port_sva import scp_pkg::*; (
  // Clock and reset
  input wire logic      clk_in,
  input wire logic      rst_b_in,
  // Watched ports
  input wire logic      init_done_in,
  input wire logic      print_active_in,
  input wire logic      txd_out,
  input wire logic      resp_valid_in,
  input wire logic      resp_ready_out,
  input wire logic      cmd_valid_out,
  input wire scp_rate_t rate_out,
  input wire logic      host_paused_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_rst;
    disable iff (1'b0) !rst_b_in |=> txd_out && !cmd_valid_out
      && !host_paused_out && rate_out == SCP_RATE_SEL_LOW;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_pulse;
    cmd_valid_out |=> !cmd_valid_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_print;
    print_active_in |-> !resp_ready_out;
  endproperty
  a_print: assert property (p_print) else $error("print");
  property p_init;
    !init_done_in |-> !resp_ready_out;
  endproperty
  a_init: assert property (p_init) else $error("init");
  property p_pause;
    host_paused_out |-> !resp_ready_out;
  endproperty
  a_pause: assert property (p_pause) else $error("pause");
  property p_start;
    resp_valid_in && resp_ready_out |=> !txd_out ##1 !resp_ready_out[*8];
  endproperty
  a_start: assert property (p_start) else $error("start bit");
  property p_rate;
    rate_out != $past(rate_out) |-> cmd_valid_out || $past(cmd_valid_out);
  endproperty
  a_rate: assert property (p_rate) else $error("rate change");
  property p_blk;
    (print_active_in || !init_done_in)[*3] |-> !cmd_valid_out;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked cmd");
  c_cmd: cover property (cmd_valid_out);
  c_tx: cover property (resp_valid_in && resp_ready_out);
  c_pause: cover property ($rose(host_paused_out));
endmodule : scp_port_sva

bind scp_port scp_port_sva chk_u (.clk_in, .rst_b_in, .init_done_in,
  .print_active_in, .txd_out, .resp_valid_in, .resp_ready_out,
  .cmd_valid_out, .rate_out, .host_paused_out);

`default_nettype wire

// *** serial_command_port_test.sv ***
`default_nettype none
`include "scp_params.svh"

// Bench for the command port
module serial_command_port_test;
  import scp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic      clk_in = 1'b0;             // Clock
  logic      rst_b_in, init_done_in;     // Reset and init
  logic      print_active_in, rxd_in;    // Print and line in
  logic      resp_valid_in, resp_last_in; // Response offer
  logic      txd_out, resp_ready_out;    // Line out, take
  logic      cmd_valid_out;              // Command pulse
  logic      host_paused_out;            // Flow state
  scp_byte_t resp_data_in;               // Response byte
  scp_byte_t cmd_first_out, cmd_second_out; // Command chars
  logic [`SCP_CMD_CNT_W-1:0] cmd_len_out; // Command length
  scp_rate_t rate_out;                   // Line rate
  int        err_total, check_count, n_cmd, cycles; // Tallies
  // Scaled core rate keeps frames short in simulation
  localparam int TB_HZ      = 768000;
  localparam int DIV_LOW    = TB_HZ / `SCP_RATE_LOW;  // Host bit lengths
  localparam int DIV_MID    = TB_HZ / `SCP_RATE_MID;
  localparam int DIV_HIGH   = TB_HZ / `SCP_RATE_HIGH;
  localparam int MAX_CYCLES = 20000;                  // Run ceiling

  scp_port #(.CLK_HZ(TB_HZ)) dut_u (.clk_in, .rst_b_in, .init_done_in,
    .print_active_in, .rxd_in, .txd_out, .resp_valid_in, .resp_data_in,
    .resp_last_in, .resp_ready_out, .cmd_valid_out, .cmd_first_out,
    .cmd_second_out, .cmd_len_out, .rate_out, .host_paused_out);
  scp_host host_u (.clk_in, .rxd_out(rxd_in), .txd_in(txd_out));

  // Clock toggle
  always #5 clk_in = ~clk_in;

  // Pulse count and run ceiling, mid-cycle where pulses are settled
  always @(negedge clk_in) begin
    cycles++;
    if (cmd_valid_out === 1'b1) n_cmd++;
    if (cycles == MAX_CYCLES) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check

  task automatic end_of_test();
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // Sends a command, counts decoded pulses
  task automatic do_cmd(input string s, input logic [7:0] np);
    int n;
    n = n_cmd;
    host_u.command(s);
    repeat (4) @(negedge clk_in);
    check(8'(n_cmd - n), np, "pulse count");
  endtask : do_cmd

  task automatic t_reset();
    rst_b_in = 1'b0;
    host_u.div = DIV_LOW;
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    check(8'(rate_out), 8'h00, "rate after reset");
    check(8'(txd_out), 8'h01, "tx idle");
  endtask : t_reset

  task automatic t_high();
    do_cmd("bc", 1);
    check(cmd_first_out, 8'h42, "fold first");
    check(cmd_second_out, 8'h43, "fold second");
    check(8'(rate_out), 8'h02, "rate high");
    host_u.div = DIV_HIGH;
  endtask : t_high

  task automatic t_blocked();
    print_active_in = 1'b1;
    do_cmd("bb", 0);
    print_active_in = 1'b0;
    init_done_in = 1'b0;
    do_cmd("ba", 0);
    init_done_in = 1'b1;
    check(8'(rate_out), 8'h02, "rate kept");
  endtask : t_blocked

  task automatic t_flow();
    int k;
    host_u.send(8'h13);
    repeat (4) @(negedge clk_in);
    check(8'(host_paused_out), 8'h01, "paused");
    resp_data_in = 8'h4F;
    resp_last_in = 1'b1;
    resp_valid_in = 1'b1;
    repeat (40) @(negedge clk_in);
    check(8'(resp_ready_out), 8'h00, "held");
    // Offer stands until the edge that samples ready high
    fork
      host_u.send(8'h11);
      begin
        for (k = 0; k < 12 * host_u.div && resp_ready_out !== 1'b1; k++)
          @(negedge clk_in);
        check(8'(resp_ready_out), 8'h01, "resumed");
        @(negedge clk_in);
        resp_valid_in = 1'b0;
      end
    join
    for (k = 0; k < 30 * host_u.div && host_u.got_q.size() < 2; k++)
      @(negedge clk_in);
    check(host_u.got_q[0], 8'h4F, "tx byte");
    check(host_u.got_q[1], 8'h0D, "tx end");
  endtask : t_flow

  task automatic t_mid();
    do_cmd("bbb", 1);
    check(8'(cmd_len_out), 8'h03, "long cmd");
    do_cmd("Bb", 1);
    check(8'(rate_out), 8'h01, "rate mid");
    host_u.div = DIV_MID;
    host_u.send(8'h0A);
    do_cmd("a", 1);
    check(8'(cmd_len_out), 8'h01, "lf dropped");
  endtask : t_mid

  // Main sequence
  initial begin
    {init_done_in, print_active_in, resp_valid_in, resp_last_in} = 4'h0;
    resp_data_in = 8'h00;
    t_reset();
    init_done_in = 1'b1;
    t_high();
    t_blocked();
    t_flow();
    t_mid();
    do_cmd("bA", 1);
    check(cmd_second_out, 8'h41, "fold low");
    check(8'(rate_out), 8'h00, "rate low");
    host_u.div = DIV_LOW;
    do_cmd("bc", 1);
    check(8'(rate_out), 8'h02, "rate high again");
    host_u.div = DIV_HIGH;
    t_reset();
    do_cmd("a", 1);
    check(8'(cmd_len_out), 8'h01, "link at reset rate");
    end_of_test();
  end
endmodule : serial_command_port_test

`default_nettype wire
